// file: core/dcl_top.sv
// converter control logic with ahb-lite register slave
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module dcl_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // chip sleep request from the controller
  input wire logic sleep_req,
  // analog side
  output dcl_pkg::dcl_analog_type analog,
  output dcl_pkg::dcl_state_type power_state
);
  import dcl_pkg::*;

  // ========================================================================
  // registers
  logic act_q;
  logic [DCL_CFG_W-1:0] cfg_q;
  logic on_q;
  logic [DCL_CODE_W-1:0] code_q;
  logic srst_q;
  logic blk_rst;
  logic sleep_s;
  logic sleeping;
  logic change;
  logic on_prev_q;
  logic [DCL_CODE_W-1:0] code_prev_q;
  dcl_req_type req_q;
  logic wr_pend_q;
  logic rd_valid;
  logic [31:0] rd_word;
  dcl_state_type state;

  // ========================================================================
  // bus address phase capture, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      req_q <= '0;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      req_q.addr <= haddr[7:0];
      req_q.write <= hwrite;
    end
  end

  // ahb response: always ready, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ========================================================================
  // block reset: system reset via async, soft reset via pulse
  assign blk_rst = srst_q;

  // soft reset pulse, self clearing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr_pend_q && req_q.addr == DCL_OFS_CTL
                && hwdata[DCL_CTL_SRST_BIT];
    end
  end

  // activation register, spared by the block reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= DCL_ACT_RST;
    end else if (wr_pend_q && req_q.addr == DCL_OFS_ACT) begin
      act_q <= hwdata[DCL_ACT_BIT];
    end
  end

  // configuration register, locked while on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= DCL_CFG_RST;
    end else if (blk_rst) begin
      cfg_q <= DCL_CFG_RST;
    end else if (wr_pend_q && req_q.addr == DCL_OFS_CFG && !on_q) begin
      cfg_q <= hwdata[DCL_CFG_W-1:0];
    end
  end

  // converter-on bit, refused while not activated
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_q <= DCL_ON_RST;
    end else if (blk_rst) begin
      on_q <= DCL_ON_RST;
    end else if (wr_pend_q && req_q.addr == DCL_OFS_CTL) begin
      on_q <= hwdata[DCL_CTL_ON_BIT] && act_q;
    end else if (!act_q) begin
      on_q <= 1'b0;
    end
  end

  // conversion code, whole 12 bits in one write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_q <= DCL_CODE_RST;
    end else if (blk_rst) begin
      code_q <= DCL_CODE_RST;
    end else if (wr_pend_q && req_q.addr == DCL_OFS_CODE) begin
      code_q <= hwdata[DCL_CODE_W-1:0];
    end
  end

  // ========================================================================
  // read mux, reserved bits and unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      DCL_OFS_ACT: rd_word[DCL_ACT_BIT] = act_q;
      DCL_OFS_CFG: rd_word[DCL_CFG_W-1:0] = cfg_q;
      DCL_OFS_CTL: rd_word[DCL_CTL_ON_BIT] = on_q;  // soft reset reads 0
      DCL_OFS_CODE: rd_word[DCL_CODE_W-1:0] = code_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end
  assign rd_valid = hready && hsel && htrans[1] && !hwrite;

  // read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_valid) begin
      hrdata <= rd_word;
    end
  end

  // ========================================================================
  // sleep input from the controller domain
  dcl_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(sleep_req),
    .dout(sleep_s)
  );
  assign sleeping = sleep_s && cfg_q[DCL_CFG_SLP_BIT];

  // change detect on on-bit and code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_prev_q <= DCL_ON_RST;
      code_prev_q <= DCL_CODE_RST;
    end else if (blk_rst) begin
      on_prev_q <= DCL_ON_RST;
      code_prev_q <= DCL_CODE_RST;  // no false change after soft reset
    end else begin
      on_prev_q <= on_q;
      code_prev_q <= code_q;
    end
  end
  assign change = (on_prev_q != on_q) || (code_prev_q != code_q);

  // power state tracker
  dcl_state u_state (
    .hclk(hclk),
    .hresetn(hresetn),
    .blk_rst(blk_rst),
    .active(act_q),
    .sleeping(sleeping),
    .on_bit(on_q),
    .change(change),
    .state(state)
  );
  assign power_state = state;

  // ========================================================================
  // analog controls, registered; all on one clock, no interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog <= '0;
    end else if (blk_rst) begin
      analog <= '0;  // follows the state reset to deactivated
    end else begin
      analog.clk_en <= act_q && !sleeping;
      analog.analog_en <= act_q && !sleeping && on_q;
      analog.pin_buf_en <= cfg_q[DCL_CFG_PIN_BIT];
      analog.int_buf_en <= cfg_q[DCL_CFG_INT_BIT];
      analog.pin_oe <= act_q && on_q && !sleeping
                       && cfg_q[DCL_CFG_PIN_BIT];
      analog.code <= code_q;  // out = vref * code / 4095
    end
  end
endmodule : dcl_top

// file: core/dcl_pkg.sv
// package of constants and types for the converter control block
// ==========================================================================
package dcl_pkg;
  // ========================================================================
  // register map
  localparam logic [7:0] DCL_OFS_ACT = 8'h00;
  localparam logic [7:0] DCL_OFS_CFG = 8'h04;
  localparam logic [7:0] DCL_OFS_CTL = 8'h08;
  localparam logic [7:0] DCL_OFS_CODE = 8'h0c;
  localparam logic [7:0] DCL_OFS_RSV_LAST = 8'h30;
  // ========================================================================
  // field positions and widths
  localparam int DCL_ACT_BIT = 0;
  localparam int DCL_CFG_INT_BIT = 0;
  localparam int DCL_CFG_PIN_BIT = 1;
  localparam int DCL_CFG_SLP_BIT = 2;
  localparam int DCL_CFG_W = 3;
  localparam int DCL_CTL_ON_BIT = 0;
  localparam int DCL_CTL_SRST_BIT = 1;
  localparam int DCL_CODE_W = 12;
  localparam logic [DCL_CODE_W-1:0] DCL_CODE_FULL = 12'h0fff;  // divisor 4095
  // ========================================================================
  // reset values
  localparam logic DCL_ACT_RST = 1'b0;
  localparam logic [DCL_CFG_W-1:0] DCL_CFG_RST = 3'h0;
  localparam logic DCL_ON_RST = 1'b0;
  localparam logic [DCL_CODE_W-1:0] DCL_CODE_RST = 12'h000;
  // ========================================================================
  // timing
  localparam int DCL_CLK_MHZ = 25;
  localparam int DCL_SETTLE_NS = 1000;  // one sample at 1 Msps
  localparam int DCL_SETTLE_CYC = (DCL_SETTLE_NS * DCL_CLK_MHZ) / 1000;
  localparam int DCL_CNT_W = 6;
  // ========================================================================
  // power states
  typedef enum logic [2:0] {
    DCL_DEACT, DCL_SLEEP, DCL_OFF, DCL_ON, DCL_CONV
  } dcl_state_type;
  // analog-side controls
  typedef struct packed {
    logic analog_en;
    logic clk_en;
    logic pin_buf_en;
    logic int_buf_en;
    logic pin_oe;
    logic [DCL_CODE_W-1:0] code;
  } dcl_analog_type;
  // ahb transfer fields
  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } dcl_req_type;
endpackage : dcl_pkg

// file: core/dcl_sync.sv
// three-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module dcl_sync (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // shift chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // accept a change once second and third agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout <= 1'b0;
    end else if (s2_q == s3_q) begin
      dout <= s3_q;
    end
  end
endmodule : dcl_sync

// file: core/dcl_state.sv
// power state tracker of the converter
`timescale 1ns/1ns
module dcl_state (
  // clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic blk_rst,
  // conditions
  input wire logic active,
  input wire logic sleeping,
  input wire logic on_bit,
  input wire logic change,
  // state out
  output dcl_pkg::dcl_state_type state
);
  import dcl_pkg::*;
  logic [DCL_CNT_W-1:0] cnt_q;
  dcl_state_type state_d;
  // next state
  always_comb begin
    state_d = state;
    case (state)
      DCL_CONV: begin
        if (cnt_q == '0) state_d = DCL_ON;
      end
      default: state_d = state;
    endcase
    if (!active) begin
      state_d = DCL_DEACT;
    end else if (sleeping) begin
      state_d = DCL_SLEEP;
    end else if (!on_bit) begin
      state_d = change ? DCL_CONV : DCL_OFF;
    end else if (change || state != DCL_CONV && state != DCL_ON) begin
      state_d = DCL_CONV;
    end
  end
  // state register, block reset returns to deactivated
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= DCL_DEACT;
    end else if (blk_rst) begin
      state <= DCL_DEACT;
    end else begin
      state <= state_d;
    end
  end
  // settle counter for one sample period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (blk_rst) begin
      cnt_q <= '0;
    end else if (state_d == DCL_CONV && state != DCL_CONV) begin
      cnt_q <= DCL_CNT_W'(DCL_SETTLE_CYC - 1);
    end else if (state_d == DCL_CONV && change) begin
      cnt_q <= DCL_CNT_W'(DCL_SETTLE_CYC - 1);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : dcl_state

// file: test/dcl_top_props.sv
// concurrent checks on the ports of the converter control block
`timescale 1ns/1ns
module dcl_top_props (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // analog side
  input wire dcl_pkg::dcl_analog_type analog,
  input wire dcl_pkg::dcl_state_type power_state
);
  import dcl_pkg::*;
  logic [7:0] conv_n;
  logic rd_go;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================================
  // helpers: read taken, length of a conversion spell
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_n <= 8'h00;
    end else begin
      conv_n <= (power_state == DCL_CONV) ? conv_n + 8'h01 : 8'h00;
    end
  end
  // ==========================================================================
  // properties
  AST_NO_WAIT: assert property (
    hreadyout == 1'b1) else $error("wait state inserted");
  AST_OKAY: assert property (
    hresp == 1'b0) else $error("error response given");
  AST_DEACT_OFF: assert property (
    power_state == DCL_DEACT |-> !analog.analog_en && !analog.clk_en)
    else $error("analog alive while deactivated");
  AST_SLEEP_OFF: assert property (
    power_state == DCL_SLEEP |-> !analog.analog_en && !analog.clk_en)
    else $error("analog alive while sleeping");
  AST_SLEEP_FLOAT: assert property (
    power_state == DCL_SLEEP |-> !analog.pin_oe) else $error("pin driven in sleep");
  AST_OFF_QUIET: assert property (
    power_state == DCL_OFF |-> !analog.analog_en) else $error("analog on while off");
  AST_ON_LIVE: assert property (
    power_state == DCL_ON |-> analog.analog_en && analog.clk_en)
    else $error("analog dead while on");
  AST_CONV_BOUND: assert property (
    conv_n <= 8'(DCL_SETTLE_CYC + 2)) else $error("conversion never settles");
  AST_UNMAPPED_ZERO: assert property (
    rd_go && haddr[7:0] > 8'h0c |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_CODE_RSV: assert property (
    rd_go && haddr[7:0] == DCL_OFS_CODE |=> hrdata[31:12] == 20'h0_0000)
    else $error("code upper bits not zero");
endmodule : dcl_top_props
bind dcl_top dcl_top_props i_dcl_top_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .analog(analog), .power_state(power_state));

// file: test/dcl_pin_model.sv
// behavioural model of the converter pin and internal output
`timescale 1ns/1ns
module dcl_pin_model #(
  parameter int VREF_MV = 3300
) (
  // controls from the block
  input wire dcl_pkg::dcl_analog_type analog,
  // millivolts on pin and internal path
  output int pin_mv,
  output int int_mv
);
  import dcl_pkg::*;
  // ladder level; pin floats at -1 when not driven
  always_comb begin
    pin_mv = (analog.analog_en && analog.pin_oe && analog.pin_buf_en) ?
      VREF_MV * int'(analog.code) / 4095 : -1;
    int_mv = (analog.analog_en && analog.int_buf_en) ?
      VREF_MV * int'(analog.code) / 4095 : 0;
  end
endmodule : dcl_pin_model

// file: test/testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
module testbench;
  import dcl_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} dcl_row_type;
  localparam int VREF_MV = 3300;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic sleep_req = 1'b0;
  logic [31:0] hrdata, rd;
  wire hready;
  logic hresp;
  dcl_analog_type analog;
  dcl_state_type power_state;
  int pin_mv, int_mv, bad_count = 0, samples_checked = 0, cyc = 0;
  dcl_row_type rows [6] = '{{8'h00, 32'hffff_ffff, 32'h0000_0001},
    {8'h04, 32'hffff_ffff, 32'h0000_0007}, {8'h0c, 32'hffff_ffff, 32'h0000_0fff},
    {8'h10, 32'hffff_ffff, 32'h0000_0000}, {8'h30, 32'hffff_ffff, 32'h0000_0000},
    {8'h04, 32'h0000_0002, 32'h0000_0002}};
  always #20 hclk = ~hclk;
  dcl_top i_dcl_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .sleep_req(sleep_req),
    .analog(analog), .power_state(power_state));
  dcl_pin_model #(.VREF_MV(VREF_MV)) i_dcl_pin_model (.analog(analog), .pin_mv(pin_mv),
    .int_mv(int_mv));
  // ==========================================================================
  // bus cycle, compares, closing
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask : rdc
  task wst(input dcl_state_type e);
    for (int i = 0; i < 60 && power_state !== e; i++) @(posedge hclk);
    chk("state", 32'(e), 32'(power_state));
  endtask : wst
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      // reserved words are only read, never written
      if (rows[i].a <= DCL_OFS_CODE) xfer(1'b1, rows[i].a, rows[i].d);
      rdc("reg", rows[i].a, rows[i].e);
    end
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 16; i += 4) rdc("rst", 8'(i), 32'h0000_0000);
    wst(DCL_DEACT);
    xfer(1'b1, DCL_OFS_CTL, 32'h0000_0001);
    rdc("on", DCL_OFS_CTL, 32'h0000_0000);
    xfer(1'b1, DCL_OFS_ACT, 32'h0000_0001);
    xfer(1'b1, DCL_OFS_CFG, 32'h0000_0007);
    xfer(1'b1, DCL_OFS_CODE, 32'h0000_0800);
    xfer(1'b1, DCL_OFS_CTL, 32'h0000_0001);
    wst(DCL_CONV);
    wst(DCL_ON);
    chk("ana", 32'({5'h1f, 12'h800}), 32'(analog));
    chk("pin", 32'(VREF_MV * 2048 / 4095), 32'(pin_mv));
    chk("int", 32'(VREF_MV * 2048 / 4095), 32'(int_mv));
    xfer(1'b1, DCL_OFS_CFG, 32'h0000_0000);
    rdc("cfg", DCL_OFS_CFG, 32'h0000_0007);
    xfer(1'b1, DCL_OFS_CODE, 32'h0000_00ff);
    wst(DCL_CONV);
    chk("code", 32'h0000_00ff, 32'(analog.code));
    sleep_req <= 1'b1;
    wst(DCL_SLEEP);
    chk("clk", 32'h0000_0000, 32'(analog.clk_en));
    chk("float", 32'hffff_ffff, 32'(pin_mv));
    sleep_req <= 1'b0;
    wst(DCL_ON);
    xfer(1'b1, DCL_OFS_CTL, 32'h0000_0000);
    wst(DCL_OFF);
    // disabled before sleep: no resume after wake
    sleep_req <= 1'b1;
    wst(DCL_SLEEP);
    sleep_req <= 1'b0;
    wst(DCL_OFF);
    xfer(1'b1, DCL_OFS_CFG, 32'h0000_0003);
    xfer(1'b1, DCL_OFS_CTL, 32'h0000_0001);
    wst(DCL_ON);
    sleep_req <= 1'b1;
    repeat (8) @(posedge hclk);
    chk("slp", 32'(DCL_ON), 32'(power_state));
    sleep_req <= 1'b0;
    xfer(1'b1, DCL_OFS_CTL, 32'h0000_0002);
    rdc("srst", DCL_OFS_CTL, 32'h0000_0000);
    rdc("cfg", DCL_OFS_CFG, 32'h0000_0000);
    rdc("code", DCL_OFS_CODE, 32'h0000_0000);
    rdc("act", DCL_OFS_ACT, 32'h0000_0001);
    xfer(1'b1, DCL_OFS_ACT, 32'h0000_0000);
    wst(DCL_DEACT);
    test_done();
  end
endmodule : testbench
